// [src/capture_compare_timer.sv]
// Purpose: Counter, prescaler, overflow and channel flag core of a 16-bit
//          timer with six capture/compare channels, behind AXI4-Lite.
// Assumes: All pin inputs are synchronous to aclk; compare values come
//          from a separate channel register block.
// Notes:   Output compare pin actions beyond the preset level live outside.
`timescale 1ns/100ps

// Behaviour
// - Clock source value 111 clocks the counter from the external pin.
// - External pin used as timer clock is forced input, ignoring direction.
// - Values 000 to 110 divide bus clock by 1..64; reset gives 000.
// - Reaching modulo sets overflow flag; next timer clock counts from zero.
// - Overflow flag clears by read-then-write-zero; new overflow wins.
// - Overflow enable gates overflow request; reset clears enable.
// - Halt bit stops counting; reset sets it.
// - While halted, input captures are suppressed.
// - Counter reset bit clears counter and prescaler, self-clears, reads zero.
// - Halt plus counter reset in one write leaves counter halted at zero.
// - High byte read latches low byte until low byte is read.
// - Counter bytes are read-only; reset and counter reset clear them.
// - Modulo high write blocks overflow flag until modulo low is written.
// - Reset sets all modulo bits.
// - Channel flag sets on active edge or on compare match.
// - Channel flag clears by read-then-write-zero; new event wins.
// - Channel enable gates channel request; reset clears enable.
// - Buffered bit on even channels disables the odd partner channel.
// - With edge/level nonzero, mode A picks compare (1) or capture (0).
// - With edge/level zero, mode A picks initial level: 1 low, 0 high.
// - Capture edges: 01 rising, 10 falling, 11 either.
module capture_compare_timer (
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	input  wire cct_pkg::axi_req_t        axi_in,
	output      cct_pkg::axi_rsp_t        axi_out,
	input  wire logic                     external_timer_clock_pin,
	input  wire logic                     port_d_bit6_direction,
	output      logic                     ext_pin_drive_enable,
	output      logic                     ext_pin_is_timer_clock,
	input  wire logic [5:0]               channel_pin_in,
	input  wire logic [5:0][15:0]         compare_value,
	output      logic [5:0]               channel_pin_out,
	output      logic [5:0]               channel_pin_oe,
	output      logic [5:0]               capture_strobe,
	output      logic [15:0]              counter_value,
	output      logic                     overflow_irq,
	output      logic [5:0]               channel_irq
);

	typedef struct packed {
		logic                        ovf_flag;
		logic                        ovf_armed;
		logic                        ovf_ie;
		logic                        halt;
		logic [2:0]                  ps;
		logic [5:0]                  presc;
		logic                        ext_prev;
		logic [15:0]                 cnt;
		logic [15:0]                 mod;
		logic                        mod_hold;
		logic                        latched;
		logic [7:0]                  low_latch;
		logic                        aw_have;
		logic [cct_pkg::ADDR_W-1:0]  aw_addr;
		logic                        w_have;
		logic [7:0]                  wdata;
		logic                        wstrb0;
		logic                        bvalid;
		logic [1:0]                  bresp;
		logic                        rvalid;
		logic [7:0]                  rdata;
		logic [1:0]                  rresp;
		logic [5:0]                  cap_strobe;
		cct_pkg::chan_t [5:0]        chan;
	} state_t;

	state_t      s_reg;
	state_t      s_next;
	logic        run;
	logic        tick;
	logic        ext_rise;
	logic [5:0]  mask;
	logic [15:0] cnt_next;
	logic        ovf_event;
	logic        do_wr;
	logic        wr_ok;
	logic [5:0]  wr_word;
	logic [5:0]  rd_word;
	logic        rd_en;
	logic        trst_wr;
	logic [5:0]  linked_off;
	logic [5:0]  cap_vec;
	logic [5:0]  ev_vec;
	logic [7:0]  rd_val;

	assign axi_out.awready = !s_reg.aw_have && !s_reg.bvalid;
	assign axi_out.wready  = !s_reg.w_have && !s_reg.bvalid;
	assign axi_out.arready = !s_reg.rvalid;
	assign axi_out.bvalid  = s_reg.bvalid;
	assign axi_out.bresp   = s_reg.bresp;
	assign axi_out.rvalid  = s_reg.rvalid;
	assign axi_out.rresp   = s_reg.rresp;
	assign axi_out.rdata   = {24'h000000, s_reg.rdata};

	// While it clocks the timer the pin is never driven by port logic.
	assign ext_pin_is_timer_clock = (s_reg.ps == cct_pkg::PS_EXTERNAL);
	assign ext_pin_drive_enable   = port_d_bit6_direction &&
	                                !ext_pin_is_timer_clock;
	assign counter_value  = s_reg.cnt;
	assign capture_strobe = s_reg.cap_strobe;
	assign overflow_irq   = s_reg.ovf_flag && s_reg.ovf_ie;

	always_comb begin
		s_next     = s_reg;
		run        = !s_reg.halt;
		rd_en      = axi_in.arvalid && !s_reg.rvalid;
		rd_word    = axi_in.araddr[7:2];
		do_wr      = s_reg.aw_have && s_reg.w_have;
		wr_word    = s_reg.aw_addr[7:2];
		wr_ok      = do_wr && s_reg.wstrb0 && (wr_word <= cct_pkg::WORD_LAST);
		trst_wr    = wr_ok && (wr_word == cct_pkg::ADDR_STATUS[7:2]) &&
		             s_reg.wdata[cct_pkg::ST_CNT_RST];
		ext_rise   = external_timer_clock_pin && !s_reg.ext_prev;
		mask       = 6'((7'h01 << s_reg.ps) - 7'h01);
		// The prescaler taps a free-running divider, so a new ratio takes
		// effect at once without waiting for a full period of the old one.
		if (s_reg.ps == cct_pkg::PS_EXTERNAL) begin
			tick = ext_rise;
		end else begin
			tick = ((s_reg.presc & mask) == mask);
		end
		if (s_reg.cnt == s_reg.mod) begin
			cnt_next = 16'h0000;
		end else begin
			cnt_next = s_reg.cnt + 16'h0001;
		end
		ovf_event = run && tick && !s_reg.mod_hold && !trst_wr &&
		            (cnt_next == s_reg.mod);

		s_next.ext_prev = external_timer_clock_pin;
		if (run) begin
			s_next.presc = s_reg.presc + 6'h01;
			if (tick) begin
				s_next.cnt = cnt_next;
			end
		end

		// Channel events.
		for (int i = 0; i < cct_pkg::NUM_CH; i++) begin
			linked_off[i] = (i % 2 == 1) && s_reg.chan[i - (i % 2)].msb;
			cap_vec[i] = run && !linked_off[i] && !s_reg.chan[i].msb &&
			             !s_reg.chan[i].msa &&
			             ((s_reg.chan[i].elsa && channel_pin_in[i] &&
			               !s_reg.chan[i].pin_prev) ||
			              (s_reg.chan[i].elsb && !channel_pin_in[i] &&
			               s_reg.chan[i].pin_prev));
			ev_vec[i]  = cap_vec[i] ||
			             (run && tick && !linked_off[i] &&
			              (s_reg.chan[i].msb || s_reg.chan[i].msa) &&
			              (cnt_next == compare_value[i]));
			s_next.chan[i].pin_prev = channel_pin_in[i];
			if ({s_reg.chan[i].elsb, s_reg.chan[i].elsa} == 2'b00) begin
				s_next.chan[i].pin_level = !s_reg.chan[i].msa;
			end
		end
		s_next.cap_strobe = cap_vec;

		// Read side effects and data.
		rd_val = 8'h00;
		case (rd_word)
			cct_pkg::ADDR_STATUS[7:2]: begin
				rd_val = {s_reg.ovf_flag, s_reg.ovf_ie, s_reg.halt,
				          2'b00, s_reg.ps};
				if (rd_en && s_reg.ovf_flag) begin
					s_next.ovf_armed = 1'b1;
				end
			end
			cct_pkg::ADDR_CNT_HI[7:2]: begin
				rd_val = s_reg.cnt[15:8];
				if (rd_en && !s_reg.latched) begin
					s_next.latched   = 1'b1;
					s_next.low_latch = s_reg.cnt[7:0];
				end
			end
			cct_pkg::ADDR_CNT_LO[7:2]: begin
				rd_val = s_reg.latched ? s_reg.low_latch : s_reg.cnt[7:0];
				if (rd_en) begin
					s_next.latched = 1'b0;
				end
			end
			cct_pkg::ADDR_MOD_HI[7:2]: rd_val = s_reg.mod[15:8];
			cct_pkg::ADDR_MOD_LO[7:2]: rd_val = s_reg.mod[7:0];
			default: begin
				for (int i = 0; i < cct_pkg::NUM_CH; i++) begin
					if ((rd_word == cct_pkg::ADDR_CH0[7:2] + 6'(i)) &&
					    !linked_off[i]) begin
						rd_val = {s_reg.chan[i].flag, s_reg.chan[i].ie,
						          s_reg.chan[i].msb, s_reg.chan[i].msa,
						          s_reg.chan[i].elsb, s_reg.chan[i].elsa,
						          s_reg.chan[i].tov, s_reg.chan[i].max};
						if (rd_en && s_reg.chan[i].flag) begin
							s_next.chan[i].armed = 1'b1;
						end
					end
				end
			end
		endcase

		// Register writes.
		if (wr_ok) begin
			case (wr_word)
				cct_pkg::ADDR_STATUS[7:2]: begin
					s_next.ovf_ie = s_reg.wdata[cct_pkg::ST_OVF_IE];
					s_next.halt   = s_reg.wdata[cct_pkg::ST_HALT];
					s_next.ps     = s_reg.wdata[2:0];
					if (!s_reg.wdata[cct_pkg::ST_OVF] && s_reg.ovf_armed) begin
						s_next.ovf_flag  = 1'b0;
						s_next.ovf_armed = 1'b0;
					end
				end
				cct_pkg::ADDR_MOD_HI[7:2]: begin
					s_next.mod[15:8] = s_reg.wdata;
					s_next.mod_hold  = 1'b1;
				end
				cct_pkg::ADDR_MOD_LO[7:2]: begin
					s_next.mod[7:0]  = s_reg.wdata;
					s_next.mod_hold  = 1'b0;
				end
				default: begin
					for (int i = 0; i < cct_pkg::NUM_CH; i++) begin
						if ((wr_word == cct_pkg::ADDR_CH0[7:2] + 6'(i)) &&
						    !linked_off[i]) begin
							s_next.chan[i].ie   = s_reg.wdata[cct_pkg::CH_IE];
							s_next.chan[i].msb  = (i % 2 == 0) &&
							                      s_reg.wdata[cct_pkg::CH_MSB];
							s_next.chan[i].msa  = s_reg.wdata[cct_pkg::CH_MSA];
							s_next.chan[i].elsb = s_reg.wdata[cct_pkg::CH_ELSB];
							s_next.chan[i].elsa = s_reg.wdata[cct_pkg::CH_ELSA];
							s_next.chan[i].tov  = s_reg.wdata[cct_pkg::CH_TOV];
							s_next.chan[i].max  = s_reg.wdata[cct_pkg::CH_MAX];
							if (!s_reg.wdata[cct_pkg::CH_FLAG] &&
							    s_reg.chan[i].armed) begin
								s_next.chan[i].flag  = 1'b0;
								s_next.chan[i].armed = 1'b0;
							end
						end
					end
				end
			endcase
		end

		// Counter reset overrides counting; the bit itself is never stored.
		if (trst_wr) begin
			s_next.cnt     = 16'h0000;
			s_next.presc   = 6'h00;
			s_next.latched = 1'b0;
		end

		// Hardware set beats a pending clear and disarms it.
		if (ovf_event) begin
			s_next.ovf_flag  = 1'b1;
			s_next.ovf_armed = 1'b0;
		end
		for (int i = 0; i < cct_pkg::NUM_CH; i++) begin
			if (ev_vec[i]) begin
				s_next.chan[i].flag  = 1'b1;
				s_next.chan[i].armed = 1'b0;
			end
		end

		// Bus channels.
		if (s_reg.bvalid && axi_in.bready) begin
			s_next.bvalid = 1'b0;
		end
		if (s_reg.rvalid && axi_in.rready) begin
			s_next.rvalid = 1'b0;
		end
		if (axi_in.awvalid && axi_out.awready) begin
			s_next.aw_have = 1'b1;
			s_next.aw_addr = axi_in.awaddr;
		end
		if (axi_in.wvalid && axi_out.wready) begin
			s_next.w_have = 1'b1;
			s_next.wdata  = axi_in.wdata[7:0];
			s_next.wstrb0 = axi_in.wstrb[0];
		end
		if (do_wr) begin
			s_next.aw_have = 1'b0;
			s_next.w_have  = 1'b0;
			s_next.bvalid  = 1'b1;
			s_next.bresp   = (wr_word <= cct_pkg::WORD_LAST) ?
			                 cct_pkg::RESP_OKAY : cct_pkg::RESP_SLVERR;
		end
		if (rd_en) begin
			s_next.rvalid = 1'b1;
			s_next.rdata  = rd_val;
			s_next.rresp  = (rd_word <= cct_pkg::WORD_LAST) ?
			                cct_pkg::RESP_OKAY : cct_pkg::RESP_SLVERR;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg       <= '0;
			s_reg.halt  <= 1'b1;
			s_reg.ps    <= cct_pkg::PS_RESET;
			s_reg.mod   <= cct_pkg::MOD_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	always_comb begin
		for (int i = 0; i < cct_pkg::NUM_CH; i++) begin
			channel_irq[i]     = s_reg.chan[i].flag && s_reg.chan[i].ie;
			channel_pin_out[i] = s_reg.chan[i].pin_level;
			// Capture pins, linked-off channels and preset channels stay with the port.
			channel_pin_oe[i]  = !linked_off[i] &&
			                     (s_reg.chan[i].msb || s_reg.chan[i].msa) &&
			                     ({s_reg.chan[i].elsb,
			                       s_reg.chan[i].elsa} != 2'b00);
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_ext_select;
		(s_reg.ps == cct_pkg::PS_EXTERNAL) |-> (tick == ext_rise) &&
		                                       !ext_pin_drive_enable;
	endproperty
	a_ext_select: assert property (p_ext_select)
		else $error("external clock selection wrong");

	property p_div8;
		(s_reg.ps == 3'h3 && tick) |-> (s_reg.presc[2:0] == 3'h7);
	endproperty
	a_div8: assert property (p_div8)
		else $error("divide by eight tick misplaced");

	property p_ovf_set;
		ovf_event |=> s_reg.ovf_flag && s_reg.cnt == $past(s_reg.mod);
	endproperty
	a_ovf_set: assert property (p_ovf_set)
		else $error("overflow did not set flag at modulo");

	property p_ovf_keep;
		(s_reg.ovf_flag && !s_reg.ovf_armed) |=> s_reg.ovf_flag;
	endproperty
	a_ovf_keep: assert property (p_ovf_keep)
		else $error("overflow flag cleared without arming read");

	property p_halt_hold;
		(s_reg.halt && !trst_wr) |=> $stable(s_reg.cnt);
	endproperty
	a_halt_hold: assert property (p_halt_hold)
		else $error("counter moved while halted");

	property p_no_capture_halted;
		s_reg.halt |-> (cap_vec == 6'h00) ##1 (capture_strobe == 6'h00);
	endproperty
	a_no_capture_halted: assert property (p_no_capture_halted)
		else $error("capture while halted");

	property p_halt_reset;
		(trst_wr && s_reg.wdata[cct_pkg::ST_HALT]) |=>
			(s_reg.cnt == 16'h0000 && s_reg.halt) [*3];
	endproperty
	a_halt_reset: assert property (p_halt_reset)
		else $error("halt with counter reset did not hold zero");

	property p_latch_hold;
		(s_reg.latched && !(rd_en && rd_word == cct_pkg::ADDR_CNT_LO[7:2]) &&
		 !trst_wr) |=> s_reg.latched && $stable(s_reg.low_latch);
	endproperty
	a_latch_hold: assert property (p_latch_hold)
		else $error("latched low byte disturbed");

	property p_mod_block;
		s_reg.mod_hold |-> !ovf_event ##1 !$rose(s_reg.ovf_flag);
	endproperty
	a_mod_block: assert property (p_mod_block)
		else $error("overflow flag set while modulo half written");

	property p_linked_quiet;
		s_reg.chan[0].msb |=> !s_reg.chan[1].flag || $past(s_reg.chan[1].flag);
	endproperty
	a_linked_quiet: assert property (p_linked_quiet)
		else $error("linked-off channel flag set");

endmodule

// [src/cct_pkg.sv]
// Purpose: Shared constants and carriers for the six-channel timer core.
// Assumes: AXI4-Lite slave with 8-bit byte address and 32-bit data.
// Notes:   Registers are 8 bits wide in the low byte of each word.
package cct_pkg;

	localparam int          NUM_CH      = 6;
	localparam int          ADDR_W      = 8;

	// Byte addresses of the registers, one aligned word each.
	localparam logic [7:0]  ADDR_STATUS = 8'h00;
	localparam logic [7:0]  ADDR_CNT_HI = 8'h04;
	localparam logic [7:0]  ADDR_CNT_LO = 8'h08;
	localparam logic [7:0]  ADDR_MOD_HI = 8'h0c;
	localparam logic [7:0]  ADDR_MOD_LO = 8'h10;
	localparam logic [7:0]  ADDR_CH0    = 8'h14;
	localparam logic [5:0]  WORD_LAST   = 6'h0a;

	// Timer status/control field positions.
	localparam int          ST_OVF      = 7;
	localparam int          ST_OVF_IE   = 6;
	localparam int          ST_HALT     = 5;
	localparam int          ST_CNT_RST  = 4;

	// Channel status/control field positions.
	localparam int          CH_FLAG     = 7;
	localparam int          CH_IE       = 6;
	localparam int          CH_MSB      = 5;
	localparam int          CH_MSA      = 4;
	localparam int          CH_ELSB     = 3;
	localparam int          CH_ELSA     = 2;
	localparam int          CH_TOV      = 1;
	localparam int          CH_MAX      = 0;

	localparam logic [2:0]  PS_EXTERNAL = 3'h7;
	localparam logic [2:0]  PS_RESET    = 3'h0;
	localparam logic [15:0] MOD_RESET   = 16'hffff;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [ADDR_W-1:0] awaddr;
		logic              awvalid;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              wvalid;
		logic              bready;
		logic [ADDR_W-1:0] araddr;
		logic              arvalid;
		logic              rready;
	} axi_req_t;

	typedef struct packed {
		logic              awready;
		logic              wready;
		logic [1:0]        bresp;
		logic              bvalid;
		logic              arready;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
		logic              rvalid;
	} axi_rsp_t;

	typedef struct packed {
		logic flag;
		logic armed;
		logic ie;
		logic msb;
		logic msa;
		logic elsb;
		logic elsa;
		logic tov;
		logic max;
		logic pin_prev;
		logic pin_level;
	} chan_t;

endpackage

// [bench/testbench.sv]
// Purpose: Self-checking bench for the six-channel timer core.
// Assumes: AXI4-Lite master tasks; all pins are driven by the bench.
// Notes:   Counts are checked with a small window where bus latency adds in.
`timescale 1ns/100ps
module testbench;
	logic              aclk;
	logic              aresetn;
	cct_pkg::axi_req_t q;
	cct_pkg::axi_rsp_t s;
	logic              ep;
	logic              dir;
	logic [5:0]        cp;
	logic [5:0][15:0]  cv;
	logic              de;
	logic              itc;
	logic [5:0]        po;
	logic [5:0]        oe;
	logic [15:0]       cnt;
	logic              oirq;
	logic [5:0]        cirq;
	logic [5:0]        strb;
	logic [15:0]       c;
	logic [7:0]        rv;
	logic [1:0]        rr;
	logic [7:0]        el [4] = '{8'h04, 8'h08, 8'h0c, 8'h0c};
	int                fail_count;
	int                cmp_count;

	capture_compare_timer dut_u (
		.aclk                     (aclk),
		.aresetn                  (aresetn),
		.axi_in                   (q),
		.axi_out                  (s),
		.external_timer_clock_pin (ep),
		.port_d_bit6_direction    (dir),
		.ext_pin_drive_enable     (de),
		.ext_pin_is_timer_clock   (itc),
		.channel_pin_in           (cp),
		.compare_value            (cv),
		.channel_pin_out          (po),
		.channel_pin_oe           (oe),
		.capture_strobe           (strb),
		.counter_value            (cnt),
		.overflow_irq             (oirq),
		.channel_irq              (cirq)
	);

	initial aclk = 1'b0;
	always #12.5 aclk = ~aclk;

	task automatic wt(input int n);
		repeat (n) @(posedge aclk);
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	// Handshakes are judged at the falling edge, where nothing moves.
	task automatic wr(input logic [7:0] a, input logic [7:0] d,
		input logic [1:0] er = cct_pkg::RESP_OKAY);
		logic       aw;
		logic       w;
		logic       b;
		logic [1:0] r;
		b = 1'b0;
		@(posedge aclk);
		q.awaddr <= a;
		q.awvalid <= 1'b1;
		q.wdata <= {24'h0, d};
		q.wvalid <= 1'b1;
		q.bready <= 1'b1;
		while (!b) begin
			@(negedge aclk);
			aw = q.awvalid & s.awready;
			w = q.wvalid & s.wready;
			b = q.bready & s.bvalid;
			r = s.bresp;
			@(posedge aclk);
			if (aw) q.awvalid <= 1'b0;
			if (w) q.wvalid <= 1'b0;
		end
		q.bready <= 1'b0;
		chk({14'h0, r}, {14'h0, er});
	endtask

	task automatic rc(input logic [7:0] a, input logic [7:0] e,
		input logic [1:0] er = cct_pkg::RESP_OKAY);
		logic ar;
		logic g;
		g = 1'b0;
		@(posedge aclk);
		q.araddr <= a;
		q.arvalid <= 1'b1;
		q.rready <= 1'b1;
		while (!g) begin
			@(negedge aclk);
			ar = q.arvalid & s.arready;
			g = q.rready & s.rvalid;
			rv = s.rdata[7:0];
			rr = s.rresp;
			@(posedge aclk);
			if (ar) q.arvalid <= 1'b0;
		end
		q.rready <= 1'b0;
		chk({6'h0, rr, rv}, {6'h0, er, e});
	endtask

	function automatic logic [7:0] ch(input int i);
		return cct_pkg::ADDR_CH0 + 8'(4 * i);
	endfunction

	task automatic tick(input int n);
		repeat (n) begin
			@(posedge aclk);
			ep <= 1'b1;
			wt(2);
			ep <= 1'b0;
			wt(1);
		end
		wt(3);
	endtask

	task automatic wrap_up();
		$display("Compares %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		wt(20000);
		fail_count++;
		wrap_up();
	end

	initial begin
		fail_count = 0;
		cmp_count = 0;
		aresetn = 1'b0;
		q = '0;
		q.wstrb = 4'h1;
		ep = 1'b0;
		dir = 1'b1;
		cp = 6'h00;
		cv = {6{16'hffff}};
		cv[4] = 16'h0003;
		wt(16);
		aresetn <= 1'b1;
		rc(cct_pkg::ADDR_STATUS, 8'h20);
		rc(cct_pkg::ADDR_CNT_HI, 8'h00);
		rc(cct_pkg::ADDR_CNT_LO, 8'h00);
		rc(cct_pkg::ADDR_MOD_HI, 8'hff);
		rc(cct_pkg::ADDR_MOD_LO, 8'hff);
		for (int i = 0; i < 6; i++) rc(ch(i), 8'h00);
		chk({9'h0, oirq, cirq}, 16'h0);
		rc(8'h2c, 8'h00, cct_pkg::RESP_SLVERR);
		wr(8'h2c, 8'hff, cct_pkg::RESP_SLVERR);
		// Each divider runs 256 cycles plus a few cycles of bus latency.
		for (int ps = 0; ps < 7; ps++) begin
			wr(cct_pkg::ADDR_STATUS, 8'h30 | 8'(ps));
			wr(cct_pkg::ADDR_STATUS, 8'(ps));
			wt(256);
			wr(cct_pkg::ADDR_STATUS, 8'h20 | 8'(ps));
			chk(16'(cnt >= (256 >> ps) - 1 && cnt <= (264 >> ps) + 1),
			    16'h0001);
		end
		c = cnt;
		wt(20);
		chk(cnt, c);
		wr(cct_pkg::ADDR_STATUS, 8'h37);
		chk({14'h0, de, itc}, 16'h1);
		wr(cct_pkg::ADDR_STATUS, 8'h07);
		tick(5);
		chk(cnt, 16'h5);
		rc(cct_pkg::ADDR_CNT_HI, 8'h00);
		tick(3);
		rc(cct_pkg::ADDR_CNT_HI, 8'h00);
		rc(cct_pkg::ADDR_CNT_LO, 8'h05);
		rc(cct_pkg::ADDR_CNT_LO, 8'h08);
		wr(cct_pkg::ADDR_CNT_LO, 8'haa);
		rc(cct_pkg::ADDR_CNT_LO, 8'h08);
		wr(cct_pkg::ADDR_STATUS, 8'h37);
		rc(cct_pkg::ADDR_STATUS, 8'h27);
		chk(cnt, 16'h0);
		rc(cct_pkg::ADDR_CNT_HI, 8'h00);
		rc(cct_pkg::ADDR_CNT_LO, 8'h00);
		wr(cct_pkg::ADDR_STATUS, 8'h30);
		chk({14'h0, de, itc}, 16'h2);
		wr(cct_pkg::ADDR_MOD_HI, 8'h00);
		wr(cct_pkg::ADDR_MOD_LO, 8'h05);
		rc(cct_pkg::ADDR_MOD_HI, 8'h00);
		rc(cct_pkg::ADDR_MOD_LO, 8'h05);
		wr(cct_pkg::ADDR_MOD_HI, 8'h00);
		wr(cct_pkg::ADDR_STATUS, 8'h00);
		wt(40);
		wr(cct_pkg::ADDR_STATUS, 8'h20);
		rc(cct_pkg::ADDR_STATUS, 8'h20);
		chk(16'(cnt <= 16'h5), 16'h1);
		wr(cct_pkg::ADDR_MOD_LO, 8'h05);
		wr(cct_pkg::ADDR_STATUS, 8'h00);
		wt(40);
		wr(cct_pkg::ADDR_STATUS, 8'h20);
		rc(cct_pkg::ADDR_STATUS, 8'ha0);
		wr(cct_pkg::ADDR_STATUS, 8'he0);
		chk({15'h0, oirq}, 16'h1);
		rc(cct_pkg::ADDR_STATUS, 8'he0);
		// The flag is cleared with the counter running, slow enough that no
		// new overflow can land inside the clearing sequence.
		wr(cct_pkg::ADDR_STATUS, 8'hd6);
		wr(cct_pkg::ADDR_STATUS, 8'h46);
		wr(cct_pkg::ADDR_STATUS, 8'h66);
		rc(cct_pkg::ADDR_STATUS, 8'h66);
		chk({15'h0, oirq}, 16'h0);
		wr(cct_pkg::ADDR_STATUS, 8'h30);
		for (int i = 0; i < 4; i++) wr(ch(i), el[i]);
		cp <= 6'h08;
		wt(3);
		cp <= 6'h00;
		wt(3);
		rc(ch(3), 8'h0c);
		wr(cct_pkg::ADDR_STATUS, 8'h00);
		cp <= 6'h0f;
		wt(1);
		@(negedge aclk);
		chk({10'h000, strb}, 16'h000d);
		wt(2);
		for (int i = 0; i < 3; i++)
			rc(ch(i), el[i] | (i == 1 ? 8'h00 : 8'h80));
		cp <= 6'h00;
		wt(3);
		rc(ch(1), 8'h88);
		wr(ch(0), 8'hc4);
		chk({15'h0, cirq[0]}, 16'h1);
		rc(ch(0), 8'hc4);
		wr(ch(0), 8'h44);
		rc(ch(0), 8'h44);
		chk({14'h0, cirq[0], oe[0]}, 16'h0);
		wr(ch(4), 8'h14);
		wt(20);
		rc(ch(4), 8'h94);
		chk({15'h0, oe[4]}, 16'h1);
		wr(ch(1), 8'h14);
		chk({15'h0, oe[1]}, 16'h1);
		wr(ch(0), 8'h24);
		wr(ch(1), 8'h10);
		rc(ch(1), 8'h00);
		chk({15'h0, oe[1]}, 16'h0);
		wr(ch(5), 8'h20);
		rc(ch(5), 8'h00);
		wr(ch(5), 8'h10);
		wt(2);
		chk({15'h0, po[5]}, 16'h0);
		rc(ch(5), 8'h10);
		wr(ch(5), 8'h00);
		wt(2);
		chk({15'h0, po[5]}, 16'h1);
		wrap_up();
	end
endmodule
